// ==== fsps_seq.sv ====
// flash self-program sequencer top, an AHB-Lite slave
// assumes a single master; store-program is a write of the key to the command word
// Function
// - reset vector is 0x0000 when boot fuse is 1, else boot loader address
// - no software path can alter fuse values
// - addresses come from 16-bit pointer; low bits word, high bits page
// - target address latched when an operation starts
// - lock bit setting ignores the pointer entirely
// - load reads address bytes; pointer bit 0 picks low or high byte
// - erase pattern plus store-program within four cycles; page field only
// - erase or write to blocking section halts the cpu
// - load pattern plus store-program stores word at word-in-page slot
// - buffer cleared after page write, on re-enable, and on reset
// - an eeprom write during loading discards the buffer
// - write pattern plus store-program; software zeroes non-page pointer bits
// - with interrupt enabled, request held while enable bit is clear
// - concurrent section blocked and busy flag set during erase or write
// - lock set programs each boot lock bit whose data bit 5:2 is zero
// - lock programming keeps all flash readable and cpu running
// - eeprom write blocks all programming and lock reads; vector status reads stay open
// - command bits auto-clear if no store-program within four cycles
// - each operation timed between 3.7 ms and 4.5 ms
// - programmed fuse and lock bits read as zero, unprogrammed as one
`timescale 1ns/10ps
module fsps_seq #(
    parameter int PROG_CYCLES = fsps_pkg::PROG_CYCLES
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // fuse and eeprom status pins
    input wire logic boot_reset_select_fuse,
    input wire logic eeprom_write_active,
    // cpu and flash side
    output logic [15:0] reset_vector,
    output logic cpu_halt,
    output logic concurrent_read_block,
    output logic spm_irq,
    output logic [15:0] flash_op_addr,
    output logic flash_erase,
    output logic flash_write,
    output logic [7:0] lock_bits
);
    typedef struct packed {
        logic ap_wr;
        logic ap_rd;
        logic [7:0] ap_addr;
        logic [7:0] ctrl;
        logic [15:0] ptr;
        logic [15:0] data;
        logic [2:0] win;
        fsps_pkg::fsps_state_t fsm;
        fsps_pkg::fsps_job_t job;
        logic busy;
        logic [7:0] locks;
        logic [15:0] vec;
        logic [2:0] settle;
        logic [1:0] ee_sync;
        logic [1:0] fuse_sync;
        logic [31:0] rdata;
        logic buf_clr;
        logic buf_ld;
        logic tmr_go;
        logic halt;
    } fsps_top_t;

    fsps_top_t st;
    fsps_top_t next_st;
    logic tmr_done;
    logic [15:0] buf_word;
    logic [fsps_pkg::WORDS-1:0] buf_used;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [6:0] pattern(input logic [7:0] c);
        pattern = c[6:0] & ~7'(1 << fsps_pkg::BIT_BUSY);
    endfunction

    function automatic logic in_blocking(input logic [fsps_pkg::PAGE_BITS-1:0] pg);
        logic [15:0] a;
        a = {3'h0, pg, 6'h0};
        in_blocking = (a >= fsps_pkg::BLOCKING_PAGE_START);
    endfunction

    // ------------------------------------------------------------
    // sub blocks
    // ------------------------------------------------------------
    fsps_page_buf u_buf (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(st.buf_clr),
        .load(st.buf_ld),
        .slot(st.ptr[fsps_pkg::WORD_BITS:1]),
        .wdata(st.data),
        .rslot(st.ptr[fsps_pkg::WORD_BITS:1]),
        .rdata(buf_word),
        .filled(buf_used)
    );

    fsps_timer #(.PROG_CYCLES(PROG_CYCLES)) u_tmr (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(st.tmr_go),
        .done(tmr_done)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic take;
        logic spm;
        logic ee;
        take = 1'b0;
        spm = 1'b0;
        ee = st.ee_sync[1];
        next_st = st;
        next_st.ee_sync = {st.ee_sync[0], eeprom_write_active};
        next_st.fuse_sync = {st.fuse_sync[0], boot_reset_select_fuse};
        next_st.buf_clr = 1'b0;
        next_st.buf_ld = 1'b0;
        next_st.tmr_go = 1'b0;
        take = hsel && hready && htrans[1];
        next_st.ap_wr = take && hwrite;
        next_st.ap_rd = take && !hwrite;
        next_st.ap_addr = haddr;
        // vector picked once, after the fuse synchroniser has filled
        next_st.settle = {st.settle[1:0], 1'b1};
        if (st.settle[1] && !st.settle[2])
        begin
            next_st.vec = st.fuse_sync[1] ? fsps_pkg::APP_RESET : fsps_pkg::BOOT_RESET;
        end
        if (st.fsm == fsps_pkg::ST_ARMED)
        begin
            if (st.win == 3'h1)
            begin
                next_st.fsm = fsps_pkg::ST_IDLE;
                next_st.ctrl[4:0] = 5'h0;
            end
            next_st.win = st.win - 3'h1;
        end
        if (st.ap_wr)
        begin
            case (st.ap_addr)
                fsps_pkg::ADDR_CTRL:
                begin
                    if (st.fsm != fsps_pkg::ST_PROG && !ee)
                    begin
                        next_st.ctrl[4:0] = hwdata[4:0];
                        next_st.ctrl[fsps_pkg::BIT_IE] = hwdata[fsps_pkg::BIT_IE];
                        next_st.fsm = hwdata[fsps_pkg::BIT_EN] ? fsps_pkg::ST_ARMED
                                                               : fsps_pkg::ST_IDLE;
                        next_st.win = fsps_pkg::WINDOW_CYCLES;
                    end
                end
                fsps_pkg::ADDR_PTR:
                begin
                    next_st.ptr = hwdata[15:0];
                end
                fsps_pkg::ADDR_DATA:
                begin
                    next_st.data = hwdata[15:0];
                end
                fsps_pkg::ADDR_CMD:
                begin
                    spm = (hwdata == fsps_pkg::CMD_KEY);
                end
                default:
                begin
                end
            endcase
        end
        // store-program only acts on an armed pattern
        if (spm && st.fsm == fsps_pkg::ST_ARMED && !ee)
        begin
            next_st.fsm = fsps_pkg::ST_IDLE;
            next_st.ctrl[4:0] = 5'h0;
            next_st.job.page = st.ptr[fsps_pkg::PAGE_LSB +: fsps_pkg::PAGE_BITS];
            next_st.job.lock_data = st.data[7:0];
            case (pattern(st.ctrl))
                fsps_pkg::PAT_LOAD:
                begin
                    next_st.buf_ld = 1'b1;
                end
                fsps_pkg::PAT_ERASE:
                begin
                    next_st.job.op = fsps_pkg::OP_ERASE;
                    next_st.job.valid = 1'b1;
                end
                fsps_pkg::PAT_WRITE:
                begin
                    next_st.job.op = fsps_pkg::OP_WRITE;
                    next_st.job.valid = 1'b1;
                end
                fsps_pkg::PAT_LOCK:
                begin
                    next_st.job.op = fsps_pkg::OP_LOCK;
                    next_st.job.page = '0;
                    next_st.job.valid = 1'b1;
                end
                // re-enable clears buffer and busy flag
                fsps_pkg::PAT_REEN:
                begin
                    next_st.buf_clr = 1'b1;
                    next_st.busy = 1'b0;
                end
                default:
                begin
                end
            endcase
            if (next_st.job.valid)
            begin
                next_st.fsm = fsps_pkg::ST_PROG;
                next_st.ctrl[fsps_pkg::BIT_EN] = 1'b1;
                next_st.tmr_go = 1'b1;
                // concurrent section busy for erase or write
                if (next_st.job.op != fsps_pkg::OP_LOCK)
                begin
                    next_st.busy = 1'b1;
                end
                next_st.halt = (next_st.job.op != fsps_pkg::OP_LOCK)
                               && in_blocking(next_st.job.page);
            end
        end
        if (ee && |buf_used)
        begin
            next_st.buf_clr = 1'b1;
        end
        if (st.fsm == fsps_pkg::ST_PROG && tmr_done)
        begin
            next_st.fsm = fsps_pkg::ST_IDLE;
            next_st.ctrl[4:0] = 5'h0;
            next_st.job.valid = 1'b0;
            next_st.halt = 1'b0;
            // program lock bits 5:2 whose data bits are zero
            if (st.job.op == fsps_pkg::OP_LOCK)
            begin
                next_st.locks[5:2] = st.locks[5:2] & st.job.lock_data[5:2];
            end
            if (st.job.op == fsps_pkg::OP_WRITE)
            begin
                next_st.buf_clr = 1'b1;
            end
        end
        next_st.rdata = 32'h0;
        if (st.ap_rd)
        begin
            case (st.ap_addr)
                fsps_pkg::ADDR_CTRL:
                begin
                    next_st.rdata = {24'h0, st.ctrl[7], st.busy, 1'b0, st.ctrl[4:0]};
                end
                fsps_pkg::ADDR_PTR:
                begin
                    next_st.rdata = {16'h0, st.ptr};
                end
                fsps_pkg::ADDR_DATA:
                begin
                    // pointer bit 0 selects byte of buffer word
                    next_st.rdata = {16'h0, st.data[15:8],
                                     st.ptr[0] ? buf_word[15:8] : buf_word[7:0]};
                end
                fsps_pkg::ADDR_STAT:
                begin
                    next_st.rdata = {16'h0, st.vec};
                end
                fsps_pkg::ADDR_LOCK:
                begin
                    // programmed bits read zero, hidden during eeprom write
                    next_st.rdata = ee ? 32'h0 : {24'h0, st.locks};
                end
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st <= '0;
            st.locks <= fsps_pkg::LOCK_RESET;
            st.fsm <= fsps_pkg::ST_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hrdata = st.rdata;
    assign hreadyout = ~st.ap_rd;
    assign hresp = 1'b0;
    // fuse is input only, never written
    assign reset_vector = st.vec;
    assign cpu_halt = st.halt;
    assign concurrent_read_block = st.busy;
    // level request while enable bit clear
    assign spm_irq = st.ctrl[fsps_pkg::BIT_IE] & ~st.ctrl[fsps_pkg::BIT_EN];
    assign flash_op_addr = {3'h0, st.job.page, 6'h0};
    assign flash_erase = st.job.valid && st.job.op == fsps_pkg::OP_ERASE;
    assign flash_write = st.job.valid && st.job.op == fsps_pkg::OP_WRITE;
    assign lock_bits = st.locks;
endmodule

// ==== fsps_pkg.sv ====
// package for the flash self-program sequencer
// assumes a 100 MHz hclk shared by all design files
package fsps_pkg;

    // ------------------------------------------------------------
    // bus map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PTR = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;
    localparam logic [7:0] ADDR_CMD = 8'h10;
    localparam logic [7:0] ADDR_LOCK = 8'h14;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int BIT_EN = 0;
    localparam int BIT_ERASE = 1;
    localparam int BIT_WRITE = 2;
    localparam int BIT_LOCK = 3;
    localparam int BIT_REEN = 4;
    localparam int BIT_BUSY = 6;
    localparam int BIT_IE = 7;
    localparam logic [6:0] PAT_LOAD = 7'h01;
    localparam logic [6:0] PAT_ERASE = 7'h03;
    localparam logic [6:0] PAT_WRITE = 7'h05;
    localparam logic [6:0] PAT_LOCK = 7'h09;
    localparam logic [6:0] PAT_REEN = 7'h11;
    localparam logic [31:0] CMD_KEY = 32'h0000_0001;

    // ------------------------------------------------------------
    // geometry and timing
    // ------------------------------------------------------------
    localparam int WORD_BITS = 5;
    localparam int WORDS = 32;
    localparam int PAGE_LSB = 6;
    localparam int PAGE_BITS = 7;
    localparam logic [15:0] BLOCKING_PAGE_START = 16'h1c00;
    localparam logic [15:0] APP_RESET = 16'h0000;
    localparam logic [15:0] BOOT_RESET = 16'h1f00;
    localparam logic [2:0] WINDOW_CYCLES = 3'h4;
    localparam int CLK_MHZ = 100;
    localparam int PROG_MIN_US = 3700;
    localparam int PROG_MAX_US = 4500;
    localparam int PROG_CYCLES = PROG_MIN_US * CLK_MHZ;
    localparam logic [7:0] LOCK_RESET = 8'hff;

    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PROG} fsps_state_t;
    typedef enum logic [1:0] {OP_ERASE, OP_WRITE, OP_LOCK} fsps_op_t;

    typedef struct packed {
        logic valid;
        fsps_op_t op;
        logic [PAGE_BITS-1:0] page;
        logic [7:0] lock_data;
    } fsps_job_t;

endpackage

// ==== fsps_page_buf.sv ====
// temporary page buffer: one word per slot, cleared as a whole
// assumes writes come from the sequencer on the same clock
`timescale 1ns/10ps
module fsps_page_buf
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic clear,
    input wire logic load,
    input wire logic [fsps_pkg::WORD_BITS-1:0] slot,
    input wire logic [15:0] wdata,
    // readout
    input wire logic [fsps_pkg::WORD_BITS-1:0] rslot,
    output logic [15:0] rdata,
    output logic [fsps_pkg::WORDS-1:0] filled
);
    typedef struct packed {
        logic [fsps_pkg::WORDS-1:0][15:0] mem;
        logic [fsps_pkg::WORDS-1:0] used;
        logic [15:0] rd;
    } fsps_buf_t;

    fsps_buf_t st;
    fsps_buf_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.rd = st.mem[rslot];
        if (clear)
        begin
            next_st.mem = '1;
            next_st.used = '0;
        end
        else if (load)
        begin
            // a second load to a used slot is undefined; it simply overwrites
            next_st.mem[slot] = wdata;
            next_st.used[slot] = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st.mem <= '1;
            st.used <= '0;
            st.rd <= 16'hffff;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata = st.rd;
    assign filled = st.used;
endmodule

// ==== fsps_timer.sv ====
// operation timer: counts one programming interval then pulses done
// assumes the hclk rate named in the package
`timescale 1ns/10ps
module fsps_timer #(
    parameter int PROG_CYCLES = fsps_pkg::PROG_CYCLES
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic start,
    output logic done
);
    typedef struct packed {
        logic run;
        logic [31:0] cnt;
        logic fin;
    } fsps_tmr_t;

    fsps_tmr_t st;
    fsps_tmr_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.fin = 1'b0;
        if (start)
        begin
            next_st.run = 1'b1;
            next_st.cnt = 32'h0;
        end
        else if (st.run)
        begin
            if (st.cnt == 32'(PROG_CYCLES - 1))
            begin
                next_st.run = 1'b0;
                next_st.fin = 1'b1;
            end
            else
            begin
                next_st.cnt = st.cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign done = st.fin;
endmodule

// ==== fsps_seq_assertions.sv ====
// checker on the sequencer top ports
// assumes binding into fsps_seq with the same PROG_CYCLES
`timescale 1ns/10ps
module fsps_chk #(
    parameter int PROG_CYCLES = fsps_pkg::PROG_CYCLES
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // observed pins
    input wire logic boot_reset_select_fuse,
    input wire logic [15:0] reset_vector,
    input wire logic cpu_halt,
    input wire logic concurrent_read_block,
    input wire logic spm_irq,
    input wire logic [15:0] flash_op_addr,
    input wire logic flash_erase,
    input wire logic flash_write,
    input wire logic [7:0] lock_bits
);
    logic [31:0] run;
    logic op;
    assign op = flash_erase | flash_write;
    // ------------------------------------------------------------
    // operation length, counted rather than unrolled
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            run <= 32'h0;
        else
            run <= op ? run + 32'h1 : 32'h0;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_vec_app:
        assert property (boot_reset_select_fuse [*4] |-> reset_vector == fsps_pkg::APP_RESET)
        else $error("vector not app start");
    a_vec_boot:
        assert property (!boot_reset_select_fuse [*4] |-> reset_vector == fsps_pkg::BOOT_RESET)
        else $error("vector not boot start");
    a_irq_idle:
        assert property (spm_irq |-> !op) else $error("irq during operation");
    a_halt_cause:
        assert property (cpu_halt |-> op && flash_op_addr >= fsps_pkg::BLOCKING_PAGE_START)
        else $error("halt without blocking target");
    a_busy_op:
        assert property (op |-> concurrent_read_block) else $error("busy low in operation");
    a_addr_held:
        assert property (op && $past(op) |-> $stable(flash_op_addr)) else $error("address moved");
    a_op_time:
        assert property ($fell(op) |-> run >= PROG_CYCLES - 1 && run <= PROG_CYCLES + 2)
        else $error("operation length wrong");
    a_lock_mono:
        assert property ((lock_bits & ~$past(lock_bits)) == 8'h0) else $error("lock bit unset");
    a_one_op:
        assert property (!(flash_erase && flash_write)) else $error("erase and write together");
    c_erase: cover property ($rose(flash_erase));
    c_halt: cover property ($rose(cpu_halt));
    c_lock: cover property ($changed(lock_bits));
endmodule
bind fsps_seq fsps_chk #(.PROG_CYCLES(PROG_CYCLES)) chk (
    .hclk,
    .hresetn,
    .boot_reset_select_fuse,
    .reset_vector,
    .cpu_halt,
    .concurrent_read_block,
    .spm_irq,
    .flash_op_addr,
    .flash_erase,
    .flash_write,
    .lock_bits
);

// ==== fsps_cpu.sv ====
// cpu core model: ahb-lite master issuing store-program sequences
// assumes hready is the slave's hreadyout
`timescale 1ns/10ps
module fsps_cpu
(
    // clock
    input wire logic hclk,
    // ahb-lite master
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [7:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial
    begin
        hsel = 1'b0;
        haddr = 8'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        // unused write bus toggles so stale data never looks valid
        hwdata <= w ? d : ~hwdata;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    // order and single loads kept by the caller
    // pattern then key, back to back
    task automatic spm(input logic [15:0] p, input logic [15:0] d, input logic [6:0] pat);
        logic [31:0] q;
        xfer(1'b1, fsps_pkg::ADDR_PTR, {16'h0, p}, q);
        xfer(1'b1, fsps_pkg::ADDR_DATA, {16'h0, d}, q);
        xfer(1'b1, fsps_pkg::ADDR_CTRL, {24'h0, 1'b1, pat}, q);
        xfer(1'b1, fsps_pkg::ADDR_CMD, fsps_pkg::CMD_KEY, q);
    endtask
endmodule

// ==== tb_top.sv ====
// self-checking bench for the flash self-program sequencer
// assumes fsps_cpu as bus master and the bound checker
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic fuse = 1'b1;
    logic eew = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, halt, crb, irq, fe, fw;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] haddr, lock;
    logic [15:0] vec, opa;
    logic [31:0] hwdata, hrdata, q;
    logic [31:0] seed = 32'h22b2d053;
    int bufm[32] = '{default: 'hffff};
    int lockm = 'hff;
    int n_fail = 0;
    int num_checks = 0;
    always #5 hclk = ~hclk;
    fsps_cpu cpu (.hclk, .hreadyout, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
    fsps_seq #(.PROG_CYCLES(20)) dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .boot_reset_select_fuse(fuse), .eeprom_write_active(eew),
        .reset_vector(vec), .cpu_halt(halt), .concurrent_read_block(crb), .spm_irq(irq),
        .flash_op_addr(opa), .flash_erase(fe), .flash_write(fw), .lock_bits(lock)
    );
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cpu.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a);
        cpu.xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic chkbuf(input int s);
        for (int h = 0; h < 2; h++)
        begin
            wr(fsps_pkg::ADDR_PTR, 32'(s * 2 + h));
            rd(fsps_pkg::ADDR_DATA);
            `CHK("buffer byte", (bufm[s] >> (8 * h)) & 'hff, q[7:0])
        end
    endtask
    task automatic wait_op();
        do rd(fsps_pkg::ADDR_CTRL); while (q[0] !== 1'b0);
    endtask
    task automatic fin(input string s);
        $display("test %s done", s);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #200000;
        n_fail++;
        conclude();
    end
    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        rd(fsps_pkg::ADDR_STAT);
        `CHK("vector", 'h0, q[15:0])
        `CHK("vector pin", fsps_pkg::APP_RESET, vec)
        wr(fsps_pkg::ADDR_STAT, 32'hffff);
        rd(fsps_pkg::ADDR_STAT);
        `CHK("vector ro", 'h0, q[15:0])
        rd(8'h3c);
        `CHK("unmapped", 'h0, q)
        `CHK("response", 1'b0, hresp)
        fin("status");
        for (int i = 0; i < 4; i++)
        begin
            bufm[i * 9] = xs() & 'hffff;
            cpu.spm(16'(i * 18), 16'(bufm[i * 9]), fsps_pkg::PAT_LOAD);
        end
        for (int i = 0; i < 4; i++)
            chkbuf(i * 9);
        wr(fsps_pkg::ADDR_PTR, 32'h6);
        wr(fsps_pkg::ADDR_CTRL, 32'h81);
        repeat (6) @(posedge hclk);
        rd(fsps_pkg::ADDR_CTRL);
        `CHK("ctrl expired", 'h0, q[4:0])
        wr(fsps_pkg::ADDR_CMD, fsps_pkg::CMD_KEY);
        chkbuf(3);
        fin("load");
        eew <= 1'b1;
        repeat (4) @(posedge hclk);
        rd(fsps_pkg::ADDR_LOCK);
        `CHK("lock hidden", 'h0, q)
        cpu.spm(16'h0040, 16'h0, fsps_pkg::PAT_ERASE);
        repeat (2) @(posedge hclk);
        `CHK("erase refused", 1'b0, fe)
        // eeprom idle before the next control write
        eew <= 1'b0;
        repeat (4) @(posedge hclk);
        bufm = '{default: 'hffff};
        chkbuf(9);
        fin("eeprom");
        cpu.spm(16'h0047, 16'h0, fsps_pkg::PAT_ERASE);
        wr(fsps_pkg::ADDR_PTR, 32'h1fff);
        `CHK("erase on", 1'b1, fe)
        `CHK("erase addr", 'h0040, opa)
        `CHK("no halt", 1'b0, halt)
        `CHK("busy pin", 1'b1, crb)
        rd(fsps_pkg::ADDR_CTRL);
        `CHK("enable held", 1'b1, q[0])
        wait_op();
        `CHK("irq", 1'b1, irq)
        `CHK("busy bit", 1'b1, q[6])
        cpu.spm(16'h0, 16'h0, fsps_pkg::PAT_REEN);
        wait_op();
        `CHK("busy cleared", 1'b0, q[6])
        fin("erase");
        cpu.spm(16'h000a, 16'h5aa5, fsps_pkg::PAT_LOAD);
        cpu.spm(16'h1c40, 16'h0, fsps_pkg::PAT_WRITE);
        @(posedge hclk);
        `CHK("write on", 1'b1, fw)
        `CHK("halt", 1'b1, halt)
        `CHK("write addr", 'h1c40, opa)
        wait_op();
        chkbuf(5);
        cpu.spm(16'h000e, 16'h1234, fsps_pkg::PAT_LOAD);
        cpu.spm(16'h0, 16'h0, fsps_pkg::PAT_REEN);
        wait_op();
        chkbuf(7);
        fin("write");
        for (int i = 0; i < 2; i++)
        begin
            q = xs();
            if (i == 0) q = {16'h0001, q[15:8], q[7:0] | 8'hc3};
            lockm = lockm & (q[7:0] | 'hc3);
            cpu.spm(q[31:16], {8'h0, q[7:0]}, fsps_pkg::PAT_LOCK);
            @(posedge hclk);
            `CHK("lock no halt", 1'b0, halt | crb)
            wait_op();
            `CHK("lock bits", lockm, lock)
            rd(fsps_pkg::ADDR_LOCK);
            `CHK("lock read", lockm, q[7:0])
        end
        fin("lock");
        cpu.spm(16'h0004, 16'h00ff, fsps_pkg::PAT_LOAD);
        hresetn <= 1'b0;
        fuse <= 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        rd(fsps_pkg::ADDR_STAT);
        `CHK("boot vector", fsps_pkg::BOOT_RESET, q[15:0])
        chkbuf(2);
        fin("reset");
        conclude();
    end
endmodule
